// [hdl/pmrs_regs.vh]
// Purpose: Offsets, fields and reset values of the mode and reset sequencer
// Assumes: Avalon-MM 32-bit words on 5-bit byte addresses
// Notes: Bits above 7 of every register read as zero
`ifndef PMRS_REGS_VH
`define PMRS_REGS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_SYSTEM_CONTROL 5'h00
`define OFS_RESET_FLAGS 5'h04
`define OFS_CLOCK_CONFIG 5'h08
`define OFS_RC_TRIM_FIRST 5'h0C
`define OFS_RC_TRIM_SECOND 5'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_SLEEP_PERMIT 7
`define BIT_PCONF_RESET_ENABLE 6
`define BIT_BUS_ERROR_ENABLE 5
`define BIT_WATCHDOG_ENABLE 4
`define BIT_SLEEP_REQUEST 7
`define BIT_SLEPT_INDICATOR 6
`define BIT_FLAG_BUS_ERROR 5
`define BIT_FLAG_WATCHDOG 4
`define BIT_FLAG_PORT_WAKE 3
`define BIT_EXT_CLOCK_ENABLE 7
`define BIT_RC_BIAS_SELECT 6
`define BIT_XTAL_ENABLE 5
`define BIT_RC_ENABLE 4
`define CPU_DIVIDER_MSB 2

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_SYSTEM_CONTROL 8'h00
`define RST_RESET_FLAGS 8'h00
`define RST_CLOCK_CONFIG 8'h10
`define RST_RC_TRIM 8'h00
`define PROGRAM_START 16'h0000

`endif

// [hdl/sync_two_flop.v]
// Purpose: Two flip-flop synchroniser for one level
// Assumes: Input is asynchronous to core_clk
// Notes: First stage feeds only the second stage
module sync_two_flop #(
    parameter RESET_VALUE = 1'b0
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Level
    input wire async_in,
    output reg sync_out
);

reg meta_reg;

always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        meta_reg <= RESET_VALUE;
        sync_out <= RESET_VALUE;
    end else begin
        meta_reg <= async_in;
        sync_out <= meta_reg;
    end
end

endmodule // sync_two_flop

// [hdl/power_mode_reset_sequencer.v]
// Purpose: Operating modes, reset distribution and sleep control
// Assumes: reset_n is the power-on reset, 40 MHz core_clk
// Notes: Sleep stops the peripheral clocks, this logic stays awake
//
// Behaviour
// [R1] Cold reset clears all, RC on, restart zero
// [R2] Port wake keeps cold-reset-only bits
// [R3] System reset clears global bits, divider, CPU
// [R4] Halt enters standby, clocks keep running
// [R5] Reset or enabled request ends standby
// [R6] Sleep stops all clocks and peripherals
// [R7] Sleep only if permit set before request
// [R8] Wake only by POR, pin, port combination; the code also wakes on an enabled watchdog or bus error source
// [R9] Slept indicator stays set until cleared
// [R10] Port wake preserves control, flags, trims
// [R11] Software puts a no-op after sleep request
// [R12] Power-on wake means data RAM lost
// [R13] Data RAM has no reset
// [R14] Accept all reset sources, distribute them
// [R15] Cold reset only from POR or pin
// [R16] System reset from cold or enabled sources
// [R17] Port-config reset gated by enable bit
// [R18] Sleep request reads zero, system reset clears
// [R19] After reset return to active mode
// [R20] Sleep reset held throughout sleep
`include "pmrs_regs.vh"

module power_mode_reset_sequencer #(
    parameter RAM_DEPTH = 512,
    parameter RAM_ADDR_W = 9
) (
    // Clock and power-on reset
    input wire core_clk,
    input wire reset_n,
    // External pin and reset sources
    input wire ext_reset_pin_n,
    input wire port_combination_wake_reset,
    input wire watchdog_reset_req,
    input wire bus_error_req,
    // CPU handshake
    input wire halt_exec,
    input wire wake_request,
    // Avalon-MM slave
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Data RAM port
    input wire ram_write,
    input wire [RAM_ADDR_W-1:0] ram_address,
    input wire [7:0] ram_wdata,
    output reg [7:0] ram_rdata,
    // Internal resets, active low
    output reg reset_cold_n,
    output reg reset_system_n,
    output reg reset_pconf_n,
    output reg reset_sleep_n,
    // Mode and clock outputs
    output reg cpu_fetch_enable,
    output reg [15:0] cpu_start_address,
    output reg clocks_enable,
    output reg rc_osc_enable,
    output reg xtal_osc_enable,
    output reg [2:0] cpu_clock_divider,
    output reg ram_contents_lost,
    output reg [1:0] mode
);

// ****************************************************************
// Modes
// ****************************************************************
localparam MODE_ACTIVE = 2'b00;
localparam MODE_STANDBY = 2'b01;
localparam MODE_SLEEP = 2'b10;
localparam MODE_RESET = 2'b11;
// The mode output carries these same codes to the core

// ****************************************************************
// Input synchronisation
// ****************************************************************
wire pin_n_sync;
wire port_wake_sync;
wire wd_sync;
wire bus_err_sync;

// Reset low: the cold reset outlasts power-on until the pin has
// been seen high through both stages
sync_two_flop #(.RESET_VALUE(1'b0)) u_pin (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(ext_reset_pin_n),
    .sync_out(pin_n_sync)
);

sync_two_flop #(.RESET_VALUE(1'b0)) u_port (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(port_combination_wake_reset),
    .sync_out(port_wake_sync)
);

sync_two_flop #(.RESET_VALUE(1'b0)) u_wd (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(watchdog_reset_req),
    .sync_out(wd_sync)
);

sync_two_flop #(.RESET_VALUE(1'b0)) u_berr (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .async_in(bus_error_req),
    .sync_out(bus_err_sync)
);

// ****************************************************************
// Registers
// ****************************************************************
reg [7:0] system_control_reg;
reg [7:0] reset_flags_reg;
reg [7:0] clock_config_reg;
reg [7:0] rc_trim_first_reg;
reg [7:0] rc_trim_second_reg;
reg [1:0] mode_reg;
reg [1:0] mode_next;
reg sleep_request_reg;
reg [7:0] ram_mem [0:RAM_DEPTH-1];

wire cold_src;
wire wd_src;
wire berr_src;
wire global_src;
wire port_src;
wire pconf_src;
wire sleep_entry;
wire wr_sel;
wire [7:0] wd8;

// ****************************************************************
// Cause decode
// ****************************************************************
assign cold_src = !pin_n_sync; // R15
// Enabled sources only; port wake counts only while asleep
assign wd_src = wd_sync && system_control_reg[`BIT_WATCHDOG_ENABLE];
assign berr_src = bus_err_sync
    && system_control_reg[`BIT_BUS_ERROR_ENABLE];
// Outside sleep the port pins carry ordinary traffic, so a matching
// pattern there must not reset the core
assign port_src = port_wake_sync && mode_reg == MODE_SLEEP; // R8
assign global_src = cold_src || wd_src || berr_src
    || port_src; // R16 R14
assign pconf_src = cold_src
    || (global_src && system_control_reg[`BIT_PCONF_RESET_ENABLE]);
assign sleep_entry = mode_next == MODE_SLEEP && !global_src;
assign wr_sel = avs_write && !avs_waitrequest;
assign wd8 = avs_writedata[7:0];

// ****************************************************************
// Mode sequencing
// ****************************************************************
always @* begin
    case (mode_reg)
    MODE_ACTIVE: begin
        // A pending sleep request outranks a halt in the same cycle
        if (sleep_request_reg)
            mode_next = MODE_SLEEP; // R7
        else if (halt_exec)
            mode_next = MODE_STANDBY; // R4
        else
            mode_next = MODE_ACTIVE;
    end
    // Clocks keep running here; only instruction fetch stops
    MODE_STANDBY: begin
        if (wake_request)
            mode_next = MODE_ACTIVE; // R5
        else
            mode_next = MODE_STANDBY;
    end
    MODE_SLEEP: mode_next = MODE_SLEEP; // R8
    MODE_RESET: mode_next = MODE_ACTIVE; // R19
    default: mode_next = MODE_RESET;
    endcase
end

// Sources override the sequence: any reset leaves standby or sleep
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        mode_reg <= MODE_RESET;
    end else if (global_src) begin
        mode_reg <= MODE_RESET; // R5 R8
    end else begin
        mode_reg <= mode_next;
    end
end

// ****************************************************************
// Register file
// ****************************************************************
// Cold bits use the power-on reset and the pin only; a port wake
// goes through the system path and leaves them untouched.
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        system_control_reg <= `RST_SYSTEM_CONTROL; // R1
        reset_flags_reg <= `RST_RESET_FLAGS;
        clock_config_reg <= `RST_CLOCK_CONFIG;
        rc_trim_first_reg <= `RST_RC_TRIM;
        rc_trim_second_reg <= `RST_RC_TRIM;
        sleep_request_reg <= 1'b0;
    end else if (cold_src) begin
        system_control_reg <= `RST_SYSTEM_CONTROL; // R1
        reset_flags_reg <= `RST_RESET_FLAGS;
        clock_config_reg <= `RST_CLOCK_CONFIG;
        rc_trim_first_reg <= `RST_RC_TRIM;
        rc_trim_second_reg <= `RST_RC_TRIM;
        sleep_request_reg <= 1'b0;
    end else if (global_src) begin
        // Flags record the cause; control and trims survive
        if (wd_src)
            reset_flags_reg[`BIT_FLAG_WATCHDOG] <= 1'b1;
        if (berr_src)
            reset_flags_reg[`BIT_FLAG_BUS_ERROR] <= 1'b1;
        if (port_src)
            reset_flags_reg[`BIT_FLAG_PORT_WAKE] <= 1'b1; // R2 R10
        // Oscillator and bias choices survive; only the divider restarts
        clock_config_reg[`CPU_DIVIDER_MSB:0] <= 3'h0; // R3
        sleep_request_reg <= 1'b0; // R18 R10
    end else begin
        // The request bit is a strobe: it lives one cycle and reads 0
        sleep_request_reg <= 1'b0;
        if (mode_reg == MODE_SLEEP)
            reset_flags_reg[`BIT_SLEPT_INDICATOR] <= 1'b1; // R9
        if (wr_sel) begin
            case (avs_address)
            `OFS_SYSTEM_CONTROL: begin
                system_control_reg[7:5] <= wd8[7:5];
                // Watchdog enable cannot be cleared by software
                if (wd8[`BIT_WATCHDOG_ENABLE])
                    system_control_reg[`BIT_WATCHDOG_ENABLE] <= 1'b1;
            end
            `OFS_RESET_FLAGS: begin
                // Permit sampled before this write takes effect
                sleep_request_reg <= wd8[`BIT_SLEEP_REQUEST]
                    && system_control_reg[`BIT_SLEEP_PERMIT]; // R7
                // Write 1 clears; a set in the same cycle wins
                if (wd8[`BIT_SLEPT_INDICATOR] && mode_reg != MODE_SLEEP)
                    reset_flags_reg[`BIT_SLEPT_INDICATOR] <= 1'b0; // R9
                if (wd8[`BIT_FLAG_BUS_ERROR])
                    reset_flags_reg[`BIT_FLAG_BUS_ERROR] <= 1'b0;
                if (wd8[`BIT_FLAG_WATCHDOG])
                    reset_flags_reg[`BIT_FLAG_WATCHDOG] <= 1'b0;
                if (wd8[`BIT_FLAG_PORT_WAKE])
                    reset_flags_reg[`BIT_FLAG_PORT_WAKE] <= 1'b0;
            end
            `OFS_CLOCK_CONFIG: clock_config_reg <= wd8;
            `OFS_RC_TRIM_FIRST: rc_trim_first_reg <= wd8;
            `OFS_RC_TRIM_SECOND: rc_trim_second_reg <= wd8;
            default: ;
            endcase
        end
    end
end

// ****************************************************************
// Avalon answer: one wait cycle, then data
// ****************************************************************
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h00000000;
    end else begin
        // Idle high, low for one cycle after a request is seen, so every
        // access costs two cycles and no wait counter is needed
        avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        case (avs_address)
        `OFS_SYSTEM_CONTROL:
            avs_readdata <= {24'h000000, system_control_reg[7:4], 4'h0};
        `OFS_RESET_FLAGS:
            avs_readdata <= {24'h000000, 1'b0,
                reset_flags_reg[6:3], 3'h0}; // R18
        `OFS_CLOCK_CONFIG:
            avs_readdata <= {24'h000000, clock_config_reg};
        `OFS_RC_TRIM_FIRST:
            avs_readdata <= {24'h000000, rc_trim_first_reg};
        `OFS_RC_TRIM_SECOND:
            avs_readdata <= {24'h000000, rc_trim_second_reg};
        default: avs_readdata <= 32'h00000000;
        endcase
    end
end

// ****************************************************************
// Internal resets and mode outputs
// ****************************************************************
// Every internal reset leaves a flip-flop, so consumers never see
// a glitch from the source decode
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        reset_cold_n <= 1'b0;
        reset_system_n <= 1'b0;
        reset_pconf_n <= 1'b0;
        reset_sleep_n <= 1'b0;
        cpu_fetch_enable <= 1'b0;
        cpu_start_address <= `PROGRAM_START;
        clocks_enable <= 1'b0;
        rc_osc_enable <= 1'b1;
        xtal_osc_enable <= 1'b0;
        cpu_clock_divider <= 3'h0;
        ram_contents_lost <= 1'b1; // R12
        mode <= MODE_RESET;
    end else begin
        reset_cold_n <= !cold_src; // R15
        reset_system_n <= !global_src; // R16 R3
        reset_pconf_n <= !pconf_src; // R17
        reset_sleep_n <= !(cold_src || sleep_entry); // R20
        cpu_fetch_enable <= !global_src
            && mode_next == MODE_ACTIVE; // R4 R19
        cpu_start_address <= `PROGRAM_START; // R1
        clocks_enable <= global_src || mode_next != MODE_SLEEP; // R6
        rc_osc_enable <= clock_config_reg[`BIT_RC_ENABLE]; // R1
        xtal_osc_enable <= clock_config_reg[`BIT_XTAL_ENABLE];
        cpu_clock_divider <= clock_config_reg[`CPU_DIVIDER_MSB:0];
        // Any RAM write means software has set up its data again
        if (cold_src)
            ram_contents_lost <= 1'b1; // R12
        else if (ram_write)
            ram_contents_lost <= 1'b0;
        mode <= global_src ? MODE_RESET : mode_next;
    end
end

// ****************************************************************
// Data RAM
// ****************************************************************
// No reset on the array; contents are undefined until written
// Read data follow the address by one clock
always @(posedge core_clk) begin
    if (ram_write)
        ram_mem[ram_address] <= ram_wdata; // R13
    ram_rdata <= ram_mem[ram_address];
end

endmodule // power_mode_reset_sequencer

// [testbench/pmrs_monitor.sv]
// Purpose: Port checker for the mode and reset sequencer
// Assumes: One clock domain, reset_n is the power-on reset
// Notes: Register-gated rules are checked only where ports show them
module pmrs_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Sources
    input wire logic ext_reset_pin_n,
    input wire logic port_combination_wake_reset,
    input wire logic halt_exec,
    input wire logic wake_request,
    // Bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Results
    input wire logic reset_cold_n,
    input wire logic reset_system_n,
    input wire logic reset_pconf_n,
    input wire logic reset_sleep_n,
    input wire logic cpu_fetch_enable,
    input wire logic [15:0] cpu_start_address,
    input wire logic clocks_enable,
    input wire logic rc_osc_enable,
    input wire logic xtal_osc_enable,
    input wire logic [1:0] mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cycles since a wake cause was last seen; saturates
    logic [3:0] cause_age;
    always_ff @(posedge core_clk or negedge reset_n)
        if (!reset_n)
            cause_age <= 4'hF;
        else if (port_combination_wake_reset || !ext_reset_pin_n)
            cause_age <= 4'h0;
        else if (cause_age != 4'hF)
            cause_age <= cause_age + 4'h1;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    property p_cold_sys; !reset_cold_n |-> !reset_system_n; endproperty
    a_cold_sys: assert property (p_cold_sys) else $error("cold w/o sys");
    property p_pconf; !reset_pconf_n |-> !reset_system_n; endproperty
    a_pconf: assert property (p_pconf) else $error("pconf w/o sys");
    property p_cold_osc;
        !reset_cold_n [*2] |-> rc_osc_enable && !xtal_osc_enable;
    endproperty
    a_cold_osc: assert property (p_cold_osc) else $error("osc");
    property p_start; cpu_start_address == 16'h0000; endproperty
    a_start: assert property (p_start) else $error("start addr");
    property p_sleep_clk;
        mode == 2'b10 |-> !clocks_enable && !cpu_fetch_enable;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("sleep clk");
    property p_sleep_rst; mode == 2'b10 |-> !reset_sleep_n; endproperty
    a_sleep_rst: assert property (p_sleep_rst) else $error("sleep rst");
    property p_standby;
        mode == 2'b01 |-> clocks_enable && !cpu_fetch_enable;
    endproperty
    a_standby: assert property (p_standby) else $error("standby");
    property p_halt;
        mode == 2'b00 && halt_exec && reset_system_n |=> mode == 2'b01;
    endproperty
    a_halt: assert property (p_halt) else $error("halt");
    property p_wake_sb; mode == 2'b01 && wake_request |=> mode == 2'b00;
    endproperty
    a_wake_sb: assert property (p_wake_sb) else $error("wake");
    property p_wake_cause;
        mode == 2'b10 ##1 mode != 2'b10 |-> cause_age < 4'h6;
    endproperty
    a_wake_cause: assert property (p_wake_cause) else $error("cause");
    property p_rd_zero;
        !avs_waitrequest && avs_read && avs_address == 4'h4
            |-> !avs_readdata[7];
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("req bit");
    property p_active; $rose(reset_system_n) |-> ##[0:4] mode == 2'b00;
    endproperty
    a_active: assert property (p_active) else $error("active");
    c_sleep_wake: cover property (mode == 2'b10 ##1 mode == 2'b11);
    c_standby: cover property (mode == 2'b01);
    c_pconf: cover property (!reset_pconf_n && reset_cold_n);
endmodule // pmrs_monitor

// [testbench/cpu_partner.sv]
// Purpose: CPU core stand-in giving halt and wake requests
// Assumes: Commands come from the bench as one-cycle pulses
// Notes: slow delays each request by one extra cycle
module cpu_partner (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bench commands
    input wire logic do_halt,
    input wire logic do_wake,
    input wire logic slow,
    // Core side
    input wire logic cpu_fetch_enable,
    output logic halt_exec,
    output logic wake_request
);
    timeunit 1ns;
    timeprecision 1ps;
    logic halt_d, wake_d;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            {halt_d, wake_d, halt_exec, wake_request} <= 4'h0;
        end else begin
            halt_d <= do_halt;
            wake_d <= do_wake;
            // A stopped core only runs no-ops, never a halt
            halt_exec <= (slow ? halt_d : do_halt) && cpu_fetch_enable;
            wake_request <= slow ? wake_d : do_wake;
        end
    end
endmodule // cpu_partner

// [testbench/power_mode_reset_sequencer_tb_top.sv]
// Purpose: Self-checking bench of the mode and reset sequencer
// Assumes: Avalon-MM master keeps the request until waitrequest is low
// Notes: Expected register values follow the documented reset classes
module power_mode_reset_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset_n, ext_reset_pin_n, port_combination_wake_reset;
    logic watchdog_reset_req, bus_error_req, halt_exec, wake_request;
    logic avs_read, avs_write, avs_waitrequest, ram_write, reset_cold_n;
    logic reset_system_n, reset_pconf_n, reset_sleep_n, cpu_fetch_enable;
    logic clocks_enable, rc_osc_enable, xtal_osc_enable, ram_contents_lost;
    logic do_halt, do_wake, slow;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [8:0] ram_address;
    logic [7:0] ram_wdata, ram_rdata;
    logic [15:0] cpu_start_address;
    logic [2:0] cpu_clock_divider;
    logic [1:0] mode;
    int failures = 0, checked = 0, cycles = 0;
    power_mode_reset_sequencer uut (.core_clk(core_clk), .reset_n(reset_n),
        .ext_reset_pin_n(ext_reset_pin_n),
        .port_combination_wake_reset(port_combination_wake_reset),
        .watchdog_reset_req(watchdog_reset_req),
        .bus_error_req(bus_error_req), .halt_exec(halt_exec),
        .wake_request(wake_request), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ram_write(ram_write),
        .ram_address(ram_address), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata), .reset_cold_n(reset_cold_n),
        .reset_system_n(reset_system_n), .reset_pconf_n(reset_pconf_n),
        .reset_sleep_n(reset_sleep_n), .cpu_fetch_enable(cpu_fetch_enable),
        .cpu_start_address(cpu_start_address),
        .clocks_enable(clocks_enable), .rc_osc_enable(rc_osc_enable),
        .xtal_osc_enable(xtal_osc_enable),
        .cpu_clock_divider(cpu_clock_divider),
        .ram_contents_lost(ram_contents_lost), .mode(mode));
    cpu_partner cpu (.core_clk(core_clk), .reset_n(reset_n),
        .do_halt(do_halt), .do_wake(do_wake), .slow(slow),
        .cpu_fetch_enable(cpu_fetch_enable), .halt_exec(halt_exec),
        .wake_request(wake_request));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Values read right after the edge are those sampled at the edge
    task automatic bus(input logic w, input logic [4:0] a,
        input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= w;
        avs_read <= !w;
        step(1);
        while (avs_waitrequest !== 1'b0) step(1);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        step(1);
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input string n, input logic [4:0] a,
        input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        check(n, q, {24'h000000, e});
    endtask
    task automatic wait_mode(input logic [1:0] m);
        for (int i = 0; i < 20 && mode !== m; i++) step(1);
        check("mode", {30'h0, mode}, {30'h0, m});
    endtask
    task automatic wait_sys();
        for (int i = 0; i < 10 && reset_system_n !== 1'b0; i++) step(1);
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_start();
        check("mode", {30'h0, mode}, 32'h0);
        check("rc", rc_osc_enable, 1'b1);
        check("xtal", xtal_osc_enable, 1'b0);
        check("start", cpu_start_address, 16'h0000);
        check("lost", ram_contents_lost, 1'b1);
        rd("clock", 4'h8, 8'h10);
        rd("ctrl", 4'h0, 8'h00);
        rd("hole", 4'h2, 8'h00);
        ram_write <= 1'b1;
        ram_address <= 9'h1FF;
        ram_wdata <= 8'hA5;
        step(1);
        ram_write <= 1'b0;
        step(2);
        check("ram", ram_rdata, 8'hA5);
        check("lost", ram_contents_lost, 1'b0);
        $display("test start done");
    endtask
    task automatic t_refuse();
        wr(4'h4, 8'h80);
        step(3);
        check("mode", {30'h0, mode}, 32'h0);
        rd("flags", 4'h4, 8'h00);
        $display("test refuse done");
    endtask
    task automatic t_standby();
        do_halt <= 1'b1;
        step(1);
        do_halt <= 1'b0;
        wait_mode(2'b01);
        check("clk", clocks_enable, 1'b1);
        slow <= 1'b1;
        do_wake <= 1'b1;
        step(1);
        do_wake <= 1'b0;
        wait_mode(2'b00);
        slow <= 1'b0;
        $display("test standby done");
    endtask
    task automatic t_port_wake();
        wr(4'h0, 8'h80);
        wr(4'h8, 8'hD3);
        wr(4'hC, 8'h5A);
        wr(5'h10, 8'hC3);
        wr(4'h4, 8'h80);
        wait_mode(2'b10);
        check("clk", clocks_enable, 1'b0);
        check("slp", reset_sleep_n, 1'b0);
        step(10);
        check("mode", {30'h0, mode}, 32'h2);
        port_combination_wake_reset <= 1'b1;
        wait_mode(2'b00);
        port_combination_wake_reset <= 1'b0;
        step(5);
        rd("ctrl", 4'h0, 8'h80);
        rd("clock", 4'h8, 8'hD0);
        check("div", cpu_clock_divider, 3'h0);
        rd("trim", 4'hC, 8'h5A);
        rd("trim2", 5'h10, 8'hC3);
        rd("flags", 4'h4, 8'h48);
        wr(4'h4, 8'h48);
        rd("flags", 4'h4, 8'h00);
        check("lost", ram_contents_lost, 1'b0);
        $display("test port wake done");
    endtask
    task automatic t_pin_wake();
        wr(4'h4, 8'h80);
        wait_mode(2'b10);
        ext_reset_pin_n <= 1'b0;
        for (int i = 0; i < 10 && reset_cold_n !== 1'b0; i++) step(1);
        check("cold", reset_cold_n, 1'b0);
        ext_reset_pin_n <= 1'b1;
        step(6);
        check("mode", {30'h0, mode}, 32'h0);
        rd("ctrl", 4'h0, 8'h00);
        rd("clock", 4'h8, 8'h10);
        $display("test pin wake done");
    endtask
    task automatic t_sources();
        wr(4'h0, 8'h50);
        watchdog_reset_req <= 1'b1;
        wait_sys();
        check("sys", reset_system_n, 1'b0);
        check("pconf", reset_pconf_n, 1'b0);
        check("cold", reset_cold_n, 1'b1);
        watchdog_reset_req <= 1'b0;
        step(6);
        rd("ctrl", 4'h0, 8'h50);
        wr(4'h0, 8'h20);
        bus_error_req <= 1'b1;
        wait_sys();
        check("pconf", reset_pconf_n, 1'b1);
        bus_error_req <= 1'b0;
        step(6);
        rd("ctrl", 4'h0, 8'h30);
        rd("flags", 4'h4, 8'h30);
        $display("test sources done");
    endtask
    initial begin
        {reset_n, ext_reset_pin_n, port_combination_wake_reset} = 3'b010;
        {watchdog_reset_req, bus_error_req, avs_read, avs_write} = 4'h0;
        {ram_write, do_halt, do_wake, slow} = 4'h0;
        {avs_address, avs_writedata} = 37'h0;
        {ram_address, ram_wdata} = 17'h0;
        step(6);
        reset_n <= 1'b1;
        step(4);
        t_start();
        t_refuse();
        t_standby();
        t_port_wake();
        t_pin_wake();
        t_sources();
        stop_test();
    end
endmodule // power_mode_reset_sequencer_tb_top
bind power_mode_reset_sequencer pmrs_monitor mon (.core_clk(core_clk),
    .reset_n(reset_n), .ext_reset_pin_n(ext_reset_pin_n),
    .port_combination_wake_reset(port_combination_wake_reset),
    .halt_exec(halt_exec), .wake_request(wake_request),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .reset_cold_n(reset_cold_n), .reset_system_n(reset_system_n),
    .reset_pconf_n(reset_pconf_n), .reset_sleep_n(reset_sleep_n),
    .cpu_fetch_enable(cpu_fetch_enable),
    .cpu_start_address(cpu_start_address), .clocks_enable(clocks_enable),
    .rc_osc_enable(rc_osc_enable), .xtal_osc_enable(xtal_osc_enable),
    .mode(mode));
